/* File: shared/gia_pkg.sv */
// constants, register map and carrier types of the group interrupt aggregator
package gia_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NSRC = 7;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_FLAGS = 16'h28a2;
    localparam logic [15:0] IDX_IN_TYPE = 16'h28a3;
    localparam logic [15:0] IDX_OUT_TYPE = 16'h28a4;
    localparam logic [15:0] IDX_ENABLES = 16'h28a5;
    localparam logic [15:0] IDX_PENDING = 16'h28a6;
    localparam logic [15:0] IDX_GATE_A = 16'h2d00;
    localparam logic [15:0] IDX_GATE_B = 16'h2d01;
    localparam logic [15:0] IDX_CORE_EN = 16'h2d10;
    localparam logic [15:0] IDX_CORE_FLAG = 16'h2d11;
    localparam logic [15:0] IDX_IRQ_STAT = 16'h2d12;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h2d13;

    localparam logic [ADDR_W-1:0] ADDR_FLAGS = {IDX_FLAGS, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IN_TYPE = {IDX_IN_TYPE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_OUT_TYPE = {IDX_OUT_TYPE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_ENABLES = {IDX_ENABLES, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PENDING = {IDX_PENDING, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_GATE_A = {IDX_GATE_A, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_GATE_B = {IDX_GATE_B, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CORE_EN = {IDX_CORE_EN, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CORE_FLAG = {IDX_CORE_FLAG, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SRC_TMR_OVF = 0;
    localparam int SRC_CAP0 = 1;
    localparam int SRC_CAP1 = 2;
    localparam int SRC_CAP2 = 3;
    localparam int SRC_SER_ILLEGAL = 4;
    localparam int SRC_SER_TX_DONE = 5;
    localparam int SRC_COMPARATOR = 6;
    localparam int GATE_A_SERIAL_BIT = 6;
    localparam int GATE_B_GROUP_BIT = 3;
    localparam int CORE_GLOBAL_EN_BIT = 7;
    localparam int CORE_EXT_EN_BIT = 3;
    localparam int CORE_EXT_FLAG_BIT = 7;
    localparam int STAT_PEND_BIT = 7;

    // ------------------------------------------------------------
    // reset values, vector, bus answers
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_IN_TYPE = 8'h7f;
    localparam logic [7:0] RST_OUT_TYPE = 8'h01;
    localparam logic [7:0] GROUP_VECTOR = 8'h5b;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef struct packed {
        logic req;
        logic [7:0] vector;
    } gia_core_t;
endpackage

/* File: verification/gia_core_model.sv */
// core-side model that takes the group request and its vector
`timescale 1ns/1ps
module gia_core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input gia_pkg::gia_core_t core_in,
    output logic [7:0] taken_vector,
    output logic [15:0] req_cycles
);
    import gia_pkg::*;
    // the core only looks at the vector while the request stands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            taken_vector <= 8'h00;
            req_cycles <= 16'h0000;
        end else if (core_in.req) begin
            taken_vector <= core_in.vector;
            req_cycles <= req_cycles + 16'h0001;
        end
    end
endmodule // gia_core_model

/* File: verification/test_gia_aggregator.sv */
// self-checking bench of the group interrupt aggregator
`timescale 1ns/1ps
module test_gia_aggregator;
    import gia_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [NSRC-1:0] src_event = '0;
    gia_core_t core_out;
    logic [7:0] taken_vector;
    logic [15:0] req_cycles;
    int error_cnt = 0, n_checks = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    gia_aggregator dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .src_event(src_event),
        .core_out(core_out), .irq(irq));
    gia_core_model core (.aclk(aclk), .aresetn(aresetn), .core_in(core_out), .taken_vector(taken_vector),
        .req_cycles(req_cycles));
    always #2.5 aclk = ~aclk;
    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic rdo(input logic [ADDR_W-1:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic rck(input string name, input logic [ADDR_W-1:0] a, input logic [7:0] e);
        rdo(a);
        chk(name, {24'h000000, e}, rd);
        chk("rresp", 32'h0, {30'h0, rs});
    endtask
    // a pulse is one cycle wide, as the sources give it
    task automatic pulse(input logic [NSRC-1:0] m);
        @(posedge aclk);
        src_event <= m;
        @(posedge aclk);
        src_event <= '0;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rck("flags", ADDR_FLAGS, 8'h00);
        rck("enables", ADDR_ENABLES, 8'h00);
        rck("pending", ADDR_PENDING, 8'h00);
        rck("in_type", ADDR_IN_TYPE, 8'h7f);
        rck("out_type", ADDR_OUT_TYPE, 8'h01);
        wr(ADDR_IN_TYPE, 8'h7f, RESP_OKAY);
        wr(ADDR_OUT_TYPE, 8'h01, RESP_OKAY);
        $display("test reset done");
        pulse(7'h7f);
        rck("flags", ADDR_FLAGS, 8'h00);
        wr(ADDR_FLAGS, 8'h7f, RESP_OKAY);
        rck("flags", ADDR_FLAGS, 8'h00);
        $display("test disabled done");
        wr(ADDR_ENABLES, 8'h7f, RESP_OKAY);
        wr(ADDR_IRQ_STAT, 8'hff, RESP_OKAY);
        pulse(7'h7f);
        rck("flags", ADDR_FLAGS, 8'h4f);
        wr(ADDR_GATE_A, 8'h40, RESP_OKAY);
        pulse(7'h30);
        rck("flags", ADDR_FLAGS, 8'h7f);
        rck("pending", ADDR_PENDING, 8'h00);
        pulse(7'h01);
        rck("pending", ADDR_PENDING, 8'h01);
        $display("test events done");
        wr(ADDR_CORE_EN, 8'h88, RESP_OKAY);
        rck("core_flag", ADDR_CORE_FLAG, 8'h00);
        chk("req", 32'h0, {31'h0, core_out.req});
        wr(ADDR_GATE_B, 8'h08, RESP_OKAY);
        rck("core_flag", ADDR_CORE_FLAG, 8'h80);
        chk("req", 32'h1, {31'h0, core_out.req});
        chk("vector", {24'h0, GROUP_VECTOR}, {24'h0, core_out.vector});
        chk("taken", {24'h0, GROUP_VECTOR}, {24'h0, taken_vector});
        chk("req_seen", 32'h1, {31'h0, req_cycles != 16'h0000});
        wr(ADDR_CORE_EN, 8'h80, RESP_OKAY);
        rck("core_en", ADDR_CORE_EN, 8'h80);
        chk("req", 32'h0, {31'h0, core_out.req});
        $display("test core done");
        wr(ADDR_FLAGS, 8'h00, RESP_OKAY);
        rck("flags", ADDR_FLAGS, 8'h00);
        rck("pending", ADDR_PENDING, 8'h01);
        wr(ADDR_CORE_FLAG, 8'h00, RESP_OKAY);
        wr(ADDR_CORE_EN, 8'h88, RESP_OKAY);
        rck("core_flag", ADDR_CORE_FLAG, 8'h00);
        chk("req", 32'h0, {31'h0, core_out.req});
        wr(ADDR_PENDING, 8'h00, RESP_OKAY);
        rck("pending", ADDR_PENDING, 8'h00);
        wr(ADDR_ENABLES, 8'h01, RESP_OKAY);
        wr(ADDR_FLAGS, 8'h03, RESP_OKAY);
        rck("flags", ADDR_FLAGS, 8'h01);
        $display("test software done");
        wr(ADDR_IRQ_STAT, 8'hff, RESP_OKAY);
        wr(ADDR_IRQ_MASK, 8'h00, RESP_OKAY);
        pulse(7'h01);
        rck("status", ADDR_IRQ_STAT, 8'h81);
        chk("irq", 32'h0, {31'h0, irq});
        wr(ADDR_IRQ_MASK, 8'h80, RESP_OKAY);
        rck("mask", ADDR_IRQ_MASK, 8'h80);
        chk("irq", 32'h1, {31'h0, irq});
        wr(ADDR_IRQ_STAT, 8'h80, RESP_OKAY);
        rck("status", ADDR_IRQ_STAT, 8'h01);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test irq done");
        rdo(18'h00000);
        chk("rdata", 32'h0, rd);
        chk("rresp", {30'h0, RESP_DECERR}, {30'h0, rs});
        wr(18'h00000, 8'h55, RESP_DECERR);
        $display("test unmapped done");
        summarize();
    end
    // every test above takes well under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        summarize();
    end
endmodule // test_gia_aggregator

/* File: verilog/gia_aggregator.sv */
// group interrupt aggregator with axi4-lite register slave
// Function
// - seven sources: overflow, three captures, serial illegal, serial done, comparator
// - group gate bit 3 of second gate register enables the whole group
// - group request goes to vector 5Bh, qualified by global and ext enables
// - an event sets its flag only while that source is enabled
// - writing one to an enabled flag raises it; disabled: no effect
// - writing zero to a flag clears it, unless an enabled event sets it in the same cycle
// - an enabled event while its flag is set sets the pending bit
// - pending bits only indicate; only software clears them
// - enable bits: one enables, zero disables, reset to zero
// - flag one means request pending; flags reset to zero
// - serial sources work only while gate register a bit 6 is one
`timescale 1ns/1ps
module gia_aggregator (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [gia_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [gia_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [gia_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [gia_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [gia_pkg::NSRC-1:0] src_event,
    output gia_pkg::gia_core_t core_out,
    output logic irq
);
    import gia_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic aw_hold_reg, w_hold_reg, w_lane_reg, bvalid_reg, rvalid_reg, wr_fire, wr_hit, rd_hit;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic we_flags, we_in, we_out, we_en, we_pend;
    logic we_gate_a, we_gate_b, we_core_en, we_core_flag, we_stat, we_mask;
    logic [7:0] w_byte_reg, rd_val, en_reg, in_type_reg, out_type_reg, gate_a_reg, gate_b_reg;
    logic [7:0] core_en_reg, irq_stat_reg, irq_mask_reg, core_vec_reg, stat_set;
    logic core_flag_reg, irq_reg, core_req_reg, group_req, core_fire, flag_wr, pend_wr;
    logic [NSRC-1:0] ev, en7, flag_vec, pend_vec, flag_set_vec, pend_set_vec, hit_mask;

    // ------------------------------------------------------------
    // write channel: address and data taken in either order
    // ------------------------------------------------------------
    assign awready = !aw_hold_reg;
    assign wready = !w_hold_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (awvalid && awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= awaddr;
        end else if (wr_fire) begin
            aw_hold_reg <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_reg <= 1'b0;
            w_byte_reg <= RST_ZERO;
            w_lane_reg <= 1'b0;
        end else if (wvalid && wready) begin
            w_hold_reg <= 1'b1;
            w_byte_reg <= wdata[7:0];
            w_lane_reg <= wstrb[0];
        end else if (wr_fire) begin
            w_hold_reg <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_DECERR;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    always_comb begin
        we_flags = 1'b0;
        we_in = 1'b0;
        we_out = 1'b0;
        we_en = 1'b0;
        we_pend = 1'b0;
        we_gate_a = 1'b0;
        we_gate_b = 1'b0;
        we_core_en = 1'b0;
        we_core_flag = 1'b0;
        we_stat = 1'b0;
        we_mask = 1'b0;
        wr_hit = 1'b1;
        if (aw_addr_reg == ADDR_FLAGS) begin
            we_flags = 1'b1;
        end else if (aw_addr_reg == ADDR_IN_TYPE) begin
            we_in = 1'b1;
        end else if (aw_addr_reg == ADDR_OUT_TYPE) begin
            we_out = 1'b1;
        end else if (aw_addr_reg == ADDR_ENABLES) begin
            we_en = 1'b1;
        end else if (aw_addr_reg == ADDR_PENDING) begin
            we_pend = 1'b1;
        end else if (aw_addr_reg == ADDR_GATE_A) begin
            we_gate_a = 1'b1;
        end else if (aw_addr_reg == ADDR_GATE_B) begin
            we_gate_b = 1'b1;
        end else if (aw_addr_reg == ADDR_CORE_EN) begin
            we_core_en = 1'b1;
        end else if (aw_addr_reg == ADDR_CORE_FLAG) begin
            we_core_flag = 1'b1;
        end else if (aw_addr_reg == ADDR_IRQ_STAT) begin
            we_stat = 1'b1;
        end else if (aw_addr_reg == ADDR_IRQ_MASK) begin
            we_mask = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end
    // a write without byte lane 0 is answered but stores nothing
    assign flag_wr = wr_fire && w_lane_reg && we_flags;
    assign pend_wr = wr_fire && w_lane_reg && we_pend;

    // ------------------------------------------------------------
    // plain control registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_reg <= RST_ZERO;
        end else if (wr_fire && w_lane_reg && we_en) begin
            en_reg <= {1'b0, w_byte_reg[NSRC-1:0]};
        end
    end
    // type registers are kept only for readback; they steer nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_type_reg <= RST_IN_TYPE;
            out_type_reg <= RST_OUT_TYPE;
        end else if (wr_fire && w_lane_reg) begin
            if (we_in) begin
                in_type_reg <= {1'b0, w_byte_reg[NSRC-1:0]};
            end
            if (we_out) begin
                out_type_reg <= {7'h00, w_byte_reg[0]};
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_a_reg <= RST_ZERO;
            gate_b_reg <= RST_ZERO;
            core_en_reg <= RST_ZERO;
            irq_mask_reg <= RST_ZERO;
        end else if (wr_fire && w_lane_reg) begin
            if (we_gate_a) begin
                gate_a_reg <= w_byte_reg;
            end
            if (we_gate_b) begin
                gate_b_reg <= w_byte_reg;
            end
            if (we_core_en) begin
                core_en_reg <= w_byte_reg;
            end
            if (we_mask) begin
                irq_mask_reg <= w_byte_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // sources, flags and pending bits
    // ------------------------------------------------------------
    always_comb begin
        ev = src_event;
        ev[SRC_SER_ILLEGAL] = src_event[SRC_SER_ILLEGAL] & gate_a_reg[GATE_A_SERIAL_BIT];
        ev[SRC_SER_TX_DONE] = src_event[SRC_SER_TX_DONE] & gate_a_reg[GATE_A_SERIAL_BIT];
    end
    assign en7 = en_reg[NSRC-1:0];
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_src
            gia_src_cell u_cell (
                .aclk(aclk),
                .aresetn(aresetn),
                .event_in(ev[gi]),
                .enable(en7[gi]),
                .flag_we(flag_wr),
                .flag_wdata(w_byte_reg[gi]),
                .pend_we(pend_wr),
                .pend_wdata(w_byte_reg[gi]),
                .flag_reg(flag_vec[gi]),
                .pend_reg(pend_vec[gi]),
                .flag_set(flag_set_vec[gi]),
                .pend_set(pend_set_vec[gi])
            );
        end
    endgenerate
    // pending bits take no part in the request
    assign group_req = gate_b_reg[GATE_B_GROUP_BIT] & |(flag_vec & en7);

    // ------------------------------------------------------------
    // core side: extended flag, enables, vector
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_flag_reg <= 1'b0;
        end else if (group_req) begin
            core_flag_reg <= 1'b1;
        end else if (wr_fire && w_lane_reg && we_core_flag) begin
            core_flag_reg <= w_byte_reg[CORE_EXT_FLAG_BIT];
        end
    end
    assign core_fire = core_flag_reg & core_en_reg[CORE_EXT_EN_BIT] & core_en_reg[CORE_GLOBAL_EN_BIT];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_req_reg <= 1'b0;
            core_vec_reg <= RST_ZERO;
        end else begin
            core_req_reg <= core_fire;
            core_vec_reg <= core_fire ? GROUP_VECTOR : RST_ZERO;
        end
    end
    assign core_out.req = core_req_reg;
    assign core_out.vector = core_vec_reg;

    // ------------------------------------------------------------
    // interrupt status: set wins over the write-one clear
    // ------------------------------------------------------------
    assign stat_set = {|pend_set_vec, flag_set_vec};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= RST_ZERO;
        end else if (wr_fire && w_lane_reg && we_stat) begin
            irq_stat_reg <= (irq_stat_reg & ~w_byte_reg) | stat_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | stat_set;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end
    assign irq = irq_reg;

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    always_comb begin
        rd_val = RST_ZERO;
        rd_hit = 1'b1;
        if (araddr == ADDR_FLAGS) begin
            rd_val = {1'b0, flag_vec};
        end else if (araddr == ADDR_IN_TYPE) begin
            rd_val = in_type_reg;
        end else if (araddr == ADDR_OUT_TYPE) begin
            rd_val = out_type_reg;
        end else if (araddr == ADDR_ENABLES) begin
            rd_val = en_reg;
        end else if (araddr == ADDR_PENDING) begin
            rd_val = {1'b0, pend_vec};
        end else if (araddr == ADDR_GATE_A) begin
            rd_val = gate_a_reg;
        end else if (araddr == ADDR_GATE_B) begin
            rd_val = gate_b_reg;
        end else if (araddr == ADDR_CORE_EN) begin
            rd_val = core_en_reg;
        end else if (araddr == ADDR_CORE_FLAG) begin
            rd_val = {core_flag_reg, 7'h00};
        end else if (araddr == ADDR_IRQ_STAT) begin
            rd_val = irq_stat_reg;
        end else if (araddr == ADDR_IRQ_MASK) begin
            rd_val = irq_mask_reg;
        end else begin
            rd_hit = 1'b0;
        end
    end
    assign arready = !rvalid_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
        end else if (arvalid && arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_DECERR;
            rdata_reg <= {24'h000000, rd_val};
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    assign hit_mask = ev & en7;
    flag_set_a: assert property ((hit_mask != '0) |=> ((flag_vec & $past(hit_mask)) == $past(hit_mask)))
        else $error("enabled event did not set its flag");
    flag_blocked_a: assert property (!flag_wr |=> ((flag_vec & ~$past(flag_vec) & ~$past(en7)) == '0))
        else $error("disabled source set its flag");
    flag_write_a: assert property ((flag_wr && hit_mask == '0) |=>
        (flag_vec == (($past(flag_vec) | $past(en7)) & $past(w_byte_reg[NSRC-1:0]))))
        else $error("flag write result wrong");
    pend_set_a: assert property ((pend_set_vec != '0) |=>
        ((pend_vec & $past(pend_set_vec)) == $past(pend_set_vec)))
        else $error("repeat event did not set pending");
    pend_keep_a: assert property (!pend_wr |=> ((~pend_vec & $past(pend_vec)) == '0))
        else $error("pending bit cleared without a write");
    serial_gate_a: assert property ((!gate_a_reg[GATE_A_SERIAL_BIT] && !flag_wr) |=>
        (flag_vec[SRC_SER_TX_DONE:SRC_SER_ILLEGAL] == $past(flag_vec[SRC_SER_TX_DONE:SRC_SER_ILLEGAL])))
        else $error("serial source acted while gated off");
    group_path_a: assert property (group_req |=> core_flag_reg ##1 (core_out.req ||
        !$past(core_en_reg[CORE_EXT_EN_BIT]) || !$past(core_en_reg[CORE_GLOBAL_EN_BIT])))
        else $error("group request did not reach the core");
    core_vec_a: assert property (core_out.req |-> core_out.vector == GROUP_VECTOR)
        else $error("core vector wrong");
    gate_block_a: assert property ((!gate_b_reg[GATE_B_GROUP_BIT] && !core_flag_reg &&
        !(wr_fire && w_lane_reg && we_core_flag)) |=> !core_flag_reg)
        else $error("core flag rose while group gate closed");
    irq_level_a: assert property (((irq_stat_reg & irq_mask_reg) != '0) |=> irq)
        else $error("unmasked status did not raise irq");
    bvalid_hold_a: assert property ((bvalid && !bready) |=> bvalid)
        else $error("write response dropped early");
    cv_flag_c: cover property (flag_set_vec != '0);
    cv_pend_c: cover property (pend_set_vec != '0);
    cv_core_c: cover property (group_req ##2 core_out.req);
    cv_write_c: cover property (wr_fire && wr_hit);
endmodule // gia_aggregator

/* File: verilog/gia_src_cell.sv */
// one source of the group: request flag and pending bit
`timescale 1ns/1ps
module gia_src_cell (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic event_in,
    input wire logic enable,
    input wire logic flag_we,
    input wire logic flag_wdata,
    input wire logic pend_we,
    input wire logic pend_wdata,
    output logic flag_reg,
    output logic pend_reg,
    output logic flag_set,
    output logic pend_set
);
    logic flag_next;
    logic pend_next;

    // ------------------------------------------------------------
    // flag
    // ------------------------------------------------------------
    assign flag_set = event_in & enable;
    // a repeat counts only while the flag is still standing
    assign pend_set = flag_set & flag_reg;

    always_comb begin
        flag_next = flag_reg;
        if (flag_we) begin
            // a one only takes while enabled; a zero clears unless an event sets the flag in the same cycle
            flag_next = flag_wdata ? (flag_reg | enable) : 1'b0;
        end
        if (flag_set) begin
            flag_next = 1'b1;
        end
    end

    // pending is only cleared by software, and an event beats the clear
    always_comb begin
        pend_next = pend_we ? pend_wdata : pend_reg;
        if (pend_set) begin
            pend_next = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_reg <= 1'b0;
            pend_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            pend_reg <= pend_next;
        end
    end
endmodule // gia_src_cell
